// ===== hw/ethernet_led_driver_defines.vh
`ifndef ETHERNET_LED_DRIVER_DEFINES_VH
`define ETHERNET_LED_DRIVER_DEFINES_VH

// Register byte offsets
`define LED_CONFIG_OFS      16'h0e00
`define LED_PIN_ROUTING_OFS 16'h8130

// Per-LED byte in led_config
`define LED_FIELD_W         8
`define LED_MODE_LSB        0
`define LED_MODE_MSB        3
`define LED_INVERT_BIT      5
`define LED_STATE_BIT       6
`define LED_BLINK_BIT       7
`define LED_CONFIG_WMASK    32'hbfbfbfbf
`define LED_BYTE_WMASK      8'hbf

// Source-select codes
`define MODE_LINK_UP        4'h0
`define MODE_FILTER_ACT     4'h1
`define MODE_LINK_ACT       4'h2
`define MODE_ACTIVITY       4'h3
`define MODE_COLLISION      4'h4
`define MODE_PAUSED         4'h5
`define MODE_ON             4'he
`define MODE_OFF            4'hf

// Reset values
`define LED_CONFIG_RST      32'h83838202
`define LED_PIN_ROUTING_RST 32'h000000e4

// EEPROM default words
`define EE_WORD_LED02       9'h01f
`define EE_WORD_LED13       9'h01c
`define EE_BASE_PORT0       9'h000
`define EE_BASE_PORT1       9'h080
`define EE_BASE_PORT2       9'h0c0
`define EE_BASE_PORT3       9'h100

// Blink timing
`define CLK_FREQ_HZ         25000000
`define BLINK_HALF_MS       200
// Half period in clocks: 25 MHz times 200 ms, sized for the counter
`define BLINK_HALF_CYCLES   23'd5000000

`endif

// ===== hw/ethernet_led_driver.v
`timescale 1ns/1ps
`include "ethernet_led_driver_defines.vh"

// How it works
// - Four LED outputs, each picking its own source through its mode field.
// - A per-LED invert bit flips the source ahead of pin and blink logic.
// - With blink set and source asserted the LED is 200 ms on, 200 ms off.
// - Link-and-traffic with blink is off, steady on, or blinking with traffic.
// - A lit LED drives its pin low, sinking the LED cathode current.
// - The led_config register at E00h holds mode, invert and blink per LED.
// - The led_pin_routing register at 8130h maps internal LEDs to pins.
// - Defaults load from EEPROM word 1Fh (LEDs 0,2) and 1Ch (LEDs 1,3).
// - Those offsets add to the port base 0h, 80h, C0h or 100h.
module ethernet_led_driver #(
    parameter [22:0] BLINK_HALF_CYCLES = `BLINK_HALF_CYCLES
) (
    input  wire        sys_clk,
    input  wire        rst_n,
    input  wire [15:0] reg_addr,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [31:0] reg_wdata,
    output reg  [31:0] reg_rdata,
    input  wire [1:0]  lan_port_id,
    output wire        ee_req,
    output wire [8:0]  ee_addr,
    input  wire        ee_ack,
    input  wire [15:0] ee_data,
    output wire        load_done,
    input  wire        link_up,
    input  wire        activity,
    input  wire        filter_activity,
    input  wire        collision,
    input  wire        paused,
    output reg  [3:0]  led_pin_n
);

    // Default load sequence, RUN holds for good
    localparam [1:0] S_START = 2'd0;
    localparam [1:0] S_RD02  = 2'd1;
    localparam [1:0] S_RD13  = 2'd2;
    localparam [1:0] S_RUN   = 2'd3;

    reg  [1:0]  state_r;
    reg  [1:0]  state_nxt;
    reg  [8:0]  ee_base_r;
    reg  [31:0] led_config_r;
    reg  [31:0] led_config_nxt;
    reg  [31:0] led_pin_routing_r;
    reg  [22:0] blink_cnt_r;
    reg         blink_phase_r;
    wire [3:0]  led_lit;
    wire [31:0] config_rd;
    wire        wr_config;
    wire        wr_routing;

    // Per-port base address
    function [8:0] port_base;
        input [1:0] id;
        begin
            case (id)
                2'd0:    port_base = `EE_BASE_PORT0;
                2'd1:    port_base = `EE_BASE_PORT1;
                2'd2:    port_base = `EE_BASE_PORT2;
                default: port_base = `EE_BASE_PORT3;
            endcase
        end
    endfunction

    // Register offset match
    function reg_hit;
        input [15:0] addr;
        input [15:0] ofs;
        begin
            reg_hit = (addr == ofs);
        end
    endfunction

    // Source selection
    function src_sel;
        input [3:0] mode;
        input       lnk;
        input       act;
        input       fact;
        input       col;
        input       pau;
        begin
            case (mode)
                `MODE_LINK_UP:    src_sel = lnk;
                `MODE_FILTER_ACT: src_sel = fact;
                `MODE_LINK_ACT:   src_sel = lnk;
                `MODE_ACTIVITY:   src_sel = act;
                `MODE_COLLISION:  src_sel = col;
                `MODE_PAUSED:     src_sel = pau;
                `MODE_ON:         src_sel = 1'b1;
                default:          src_sel = 1'b0;
            endcase
        end
    endfunction

    // EEPROM default load sequence
    // Word select
    assign ee_req    = (state_r == S_RD02) || (state_r == S_RD13);
    assign ee_addr   = ee_base_r +
                       ((state_r == S_RD13) ? `EE_WORD_LED13 : `EE_WORD_LED02);
    assign load_done = (state_r == S_RUN);
    assign wr_config  = reg_wr && reg_hit(reg_addr, `LED_CONFIG_OFS);
    assign wr_routing = reg_wr && reg_hit(reg_addr, `LED_PIN_ROUTING_OFS);

    // Each word waits for its answer
    always @* begin
        state_nxt = state_r;
        case (state_r)
            S_START: state_nxt = S_RD02;
            S_RD02:  if (ee_ack) state_nxt = S_RD13;
            S_RD13:  if (ee_ack) state_nxt = S_RUN;
            S_RUN:   state_nxt = S_RUN;
            default: state_nxt = S_START;
        endcase
    end

    always @* begin
        led_config_nxt = led_config_r;
        if (wr_config)
            led_config_nxt = reg_wdata & `LED_CONFIG_WMASK;
        // EEPROM words beat a same-cycle write
        // LEDs 0 and 2 default
        if (state_r == S_RD02 && ee_ack) begin
            led_config_nxt[7:0]   = ee_data[7:0] & `LED_BYTE_WMASK;
            led_config_nxt[23:16] = ee_data[15:8] & `LED_BYTE_WMASK;
        end
        if (state_r == S_RD13 && ee_ack) begin
            led_config_nxt[15:8]  = ee_data[7:0] & `LED_BYTE_WMASK;
            led_config_nxt[31:24] = ee_data[15:8] & `LED_BYTE_WMASK;
        end
    end

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            state_r           <= S_START;
            ee_base_r         <= `EE_BASE_PORT0;
            led_config_r      <= `LED_CONFIG_RST;
            led_pin_routing_r <= `LED_PIN_ROUTING_RST;
        end else begin
            state_r      <= state_nxt;
            led_config_r <= led_config_nxt;
            if (state_r == S_START)
                ee_base_r <= port_base(lan_port_id);
            if (wr_routing)
                led_pin_routing_r <= {24'h000000, reg_wdata[7:0]};
        end
    end

    // Shared blink phase
    // Phase starts dark after reset
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            blink_cnt_r   <= 23'h000000;
            blink_phase_r <= 1'b0;
        end else if (blink_cnt_r == BLINK_HALF_CYCLES - 23'h000001) begin
            blink_cnt_r   <= 23'h000000;
            blink_phase_r <= ~blink_phase_r;
        end else begin
            blink_cnt_r <= blink_cnt_r + 23'h000001;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_led
            wire [7:0] fld = led_config_r[gi*8 +: 8];
            wire [3:0] mode = fld[`LED_MODE_MSB:`LED_MODE_LSB];
            wire       blink = fld[`LED_BLINK_BIT];
            wire       src = src_sel(mode, link_up, activity,
                                     filter_activity, collision, paused)
                             ^ fld[`LED_INVERT_BIT];
            wire       blink_now = (mode == `MODE_LINK_ACT) ?
                                   (activity ^ fld[`LED_INVERT_BIT]) : 1'b1;
            assign led_lit[gi] = blink ?
                                 (src & (blink_now ? blink_phase_r : 1'b1)) :
                                 src;
            // Bit 6 reads back the lit state
            assign config_rd[gi*8 +: 8] = {fld[7], led_lit[gi], fld[5:0]};
        end
    endgenerate

    integer pi;
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            led_pin_n <= 4'hf;
        end else begin
            for (pi = 0; pi < 4; pi = pi + 1)
                led_pin_n[pi] <= ~led_lit[led_pin_routing_r[pi*2 +: 2]];
        end
    end

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                `LED_CONFIG_OFS:      reg_rdata <= config_rd;
                `LED_PIN_ROUTING_OFS: reg_rdata <= led_pin_routing_r;
                // Unmapped reads return zero
                default:              reg_rdata <= 32'h00000000;
            endcase
        end
    end

endmodule

// ===== dv/ee_model.sv
`timescale 1ns/1ps
module ee_model #(
    parameter [15:0] W02 = 16'h0f0f,
    parameter [15:0] W13 = 16'h0e0f
) (
    input  wire        sys_clk,
    input  wire        ee_req,
    input  wire [8:0]  ee_addr,
    output reg         ee_ack,
    output reg  [15:0] ee_data
);
    reg [1:0] cnt_r = 2'h0;
    initial ee_ack = 1'b0;
    initial ee_data = 16'h0;
    // Slow answer, data toggles outside the ack cycle
    always @(posedge sys_clk) begin
        ee_ack <= 1'b0;
        ee_data <= ~ee_data;
        if (ee_req && !ee_ack) begin
            cnt_r <= cnt_r + 2'h1;
            if (cnt_r == 2'h3) begin
                ee_ack <= 1'b1;
                ee_data <= (ee_addr[1:0] == 2'h3) ? W02 : W13;
            end
        end
    end
endmodule

// ===== dv/led_drv_assertions.sv
`timescale 1ns/1ps
module led_drv_assertions (
    input wire        sys_clk,
    input wire        rst_n,
    input wire [15:0] reg_addr,
    input wire        reg_rd,
    input wire [31:0] reg_rdata,
    input wire [1:0]  lan_port_id,
    input wire        ee_req,
    input wire [8:0]  ee_addr,
    input wire        ee_ack,
    input wire        load_done,
    input wire [3:0]  led_pin_n
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire [8:0] base = lan_port_id[1] ? (lan_port_id[0] ? 9'h100 : 9'h0c0)
                                     : {1'b0, lan_port_id[0], 7'h0};
    wire       unmap = reg_addr != 16'h0e00 && reg_addr != 16'h8130;
    wire       at02  = ee_addr == base + 9'h01f;
    wire       at13  = ee_addr == base + 9'h01c;
    sequence ack02; ee_req && ee_ack && at02; endsequence
    sequence ack13; ee_req && ee_ack && at13; endsequence
    rst_dark_a: assert property (disable iff (1'b0)
        !rst_n |=> led_pin_n == 4'hf)
        else $error("pins lit in reset");
    ee_order_a: assert property (ack02 |=> ee_req && at13)
        else $error("second word not next");
    ee_done_a: assert property (ack13 |=> !ee_req && load_done)
        else $error("load not done");
    ee_hold_a: assert property (
        ee_req && !ee_ack |=> ee_req && $stable(ee_addr))
        else $error("request dropped");
    ee_base_a: assert property (ee_req |-> at02 || at13)
        else $error("bad word address");
    done_stay_a: assert property (load_done |=> load_done)
        else $error("done fell");
    rd_unmap_a: assert property (
        reg_rd && unmap |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    rd_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved");
    rd_route_a: assert property (
        reg_rd && !unmap && reg_addr[15] |=> reg_rdata[31:8] == 24'h0)
        else $error("routing upper bits set");
endmodule

// ===== dv/tb.sv
`timescale 1ns/1ps
module tb;
    reg          sys_clk, rst_n, reg_wr, reg_rd, rd_d, lit;
    reg  [15:0]  reg_addr;
    reg  [31:0]  reg_wdata, seed, d;
    reg  [1:0]   lan_port_id;
    reg  [4:0]   src;
    reg  [3:0]   m;
    wire [31:0]  reg_rdata;
    wire [15:0]  ee_data;
    wire [8:0]   ee_addr;
    wire [3:0]   led_pin_n;
    wire         ee_req, ee_ack, load_done;
    integer      n_fail, total_checks, i, s, n;
    logic [31:0] exp_q [$];
    ethernet_led_driver #(.BLINK_HALF_CYCLES(23'd8)) i_ethernet_led_driver (
        .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .lan_port_id(lan_port_id), .ee_req(ee_req), .ee_addr(ee_addr),
        .ee_ack(ee_ack), .ee_data(ee_data), .load_done(load_done),
        .link_up(src[0]), .activity(src[1]), .filter_activity(src[2]),
        .collision(src[3]), .paused(src[4]), .led_pin_n(led_pin_n));
    ee_model i_ee_model (.sys_clk(sys_clk), .ee_req(ee_req), .ee_addr(ee_addr),
        .ee_ack(ee_ack), .ee_data(ee_data));
    function [31:0] rnd(input [31:0] x);
        rnd = x ^ (x << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
    endfunction
    task chk(input [31:0] got, input [31:0] exp);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wr(input [15:0] a, input [31:0] v);
        @(negedge sys_clk) {reg_addr, reg_wdata, reg_wr} = {a, v, 1'b1};
        @(negedge sys_clk) reg_wr = 1'b0;
        repeat (2) @(negedge sys_clk);
    endtask
    task rd(input [15:0] a, input [31:0] e);
        @(negedge sys_clk) {reg_addr, reg_rd} = {a, 1'b1};
        exp_q.push_back(e);
        @(negedge sys_clk) reg_rd = 1'b0;
    endtask
    task cnt(input integer e);
        n = 0;
        repeat (32) @(negedge sys_clk) n = n + !led_pin_n[0];
        chk(n, e);
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Read results come off the queue in order
    always @(posedge sys_clk) rd_d <= reg_rd;
    always @(negedge sys_clk)
        if (rd_d === 1'b1) chk(reg_rdata, exp_q.pop_front());
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (6000) @(posedge sys_clk);
        n_fail = n_fail + 1;
        stop_test;
    end
    initial begin
        {n_fail, total_checks, rd_d, reg_wr, reg_rd, src} = 0;
        {reg_addr, reg_wdata} = 0;
        seed = rnd(32'h7761);
        lan_port_id = seed[1:0];
        rst_n = 1'b0;
        repeat (8) @(negedge sys_clk);
        rst_n = 1'b1;
        for (i = 0; i < 200 && load_done !== 1'b1; i = i + 1)
            @(negedge sys_clk);
        // Pins follow the loaded config one clock later
        @(negedge sys_clk);
        chk(load_done, 32'h1);
        chk(led_pin_n, 32'h7);
        rd(16'h0e00, 32'h4e0f0f0f);
        for (i = 0; i < 4; i = i + 1) begin
            seed = rnd(seed);
            d = (seed & 32'h90909090) | 32'h0f0f0f0f;
            wr(16'h0e00, d);
            rd(16'h0e00, d);
        end
        rd(16'h0e04, 32'h0);
        for (s = 0; s < 2; s = s + 1) for (i = 0; i < 7; i = i + 1) begin
            m = 28'h01345ef >> (4 * i);
            src = {5{s[0]}};
            wr(16'h0e00, {2{4'h0, m, 4'h0, m}} | 32'h20200000);
            lit = m == 4'he || (m < 4'h6 && s[0]);
            chk(led_pin_n, {lit, lit, !lit, !lit});
        end
        wr(16'h8130, 32'hffffff1b);
        rd(16'h8130, 32'h1b);
        wr(16'h0e00, 32'h0f0f0f0e);
        chk(led_pin_n, 32'h7);
        wr(16'h8130, 32'he4);
        // Blink on, invert clear, link and traffic
        wr(16'h0e00, 32'h0f0f0f82);
        src = 5'h0;
        cnt(0);
        src = 5'h1;
        cnt(32);
        src = 5'h3;
        repeat (2) @(negedge sys_clk);
        cnt(16);
        stop_test;
    end
endmodule
bind ethernet_led_driver led_drv_assertions i_led_drv_assertions (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .lan_port_id(lan_port_id), .ee_req(ee_req),
    .ee_addr(ee_addr), .ee_ack(ee_ack), .load_done(load_done),
    .led_pin_n(led_pin_n));
